// ==== rtl/fpt_flash_protect.sv ====
// Flash controller protection, keyed page unlock and trim override logic.
// Assumes an APB master on the register side and a flash array that
// acts on one-cycle program and page erase strobes and on a mass erase that lasts as long as the debug request.
`timescale 1ns/100ps
`default_nettype none

// How it works
// - Option bit 0 blocks user program and erase
// - Option bit 1 allows program and erase
// - Any reset leaves controller locked
// - Page mismatch relocks; match activates page
// - 95H erases page only if sector unprotected
// - Other control values or post-program writes relock
// - Mass erase only from debug port
// - Unlocked page accepts repeated byte writes
// - Up to eight sectors, never below page
// - 73H then 5EH redirects next page-select write
// - Sector protect clears to zero on reset
// - Protected sector refuses CPU program and erase
// - Thirty-two working trim bytes
// - Trim data write replaces addressed working byte
// - Trim data read returns addressed working byte
// - Reset restores factory trim values
// - Trim reaches addresses 00-1F only
// - Serial bytes survive mass erase
module fpt_flash_protect
    import fpt_pkg::*;
#(
    parameter int PAGE_BITS = 2,  // Number of page address bits
    parameter int OFFS_BITS = 9   // Byte offset bits within a page
) (
    // Clock and reset
    input  wire  logic                        clk_i,
    input  wire  logic                        rst_n_i,
    // APB slave
    input  wire  logic                        psel_i,
    input  wire  logic                        penable_i,
    input  wire  logic                        pwrite_i,
    input  wire  logic [FPT_ADDR_W-1:0]       paddr_i,
    input  wire  logic [31:0]                 pwdata_i,
    output logic       [31:0]                 prdata_o,
    output logic                              pready_o,
    output logic                              pslverr_o,
    // Option bit and debugger
    input  wire  logic                        flash_write_protect_option_i,
    input  wire  logic                        dbg_mass_erase_i,
    // Factory trim bytes from the information page
    input  wire  logic [FPT_TRIM_BYTES*8-1:0] factory_trim_i,
    // Flash array strobes
    output logic                              prog_stb_o,
    output logic                              erase_stb_o,
    output logic                              mass_erase_o,
    output logic       [PAGE_BITS+OFFS_BITS-1:0] flash_addr_o,
    output logic       [7:0]                  flash_wdata_o,
    // Working trim bytes to the analog blocks
    output logic       [FPT_TRIM_BYTES*8-1:0] trim_value_o
);

    // Refuse geometries the sector mapping cannot serve
    if (PAGE_BITS < 1 || PAGE_BITS > 8 || OFFS_BITS < 1 || OFFS_BITS > 8 + 16) begin : g_chk
        $error("fpt_flash_protect: unsupported PAGE_BITS or OFFS_BITS");
    end

    localparam int NUM_PAGES = 1 << PAGE_BITS; // Pages in the array
    // Page bits below the sector field; zero keeps small arrays legal
    localparam int SECT_SHIFT = (PAGE_BITS > 3) ? PAGE_BITS - 3 : 0;

    // All state of the block
    typedef struct packed {
        fpt_state_type                        state;      // Controller state
        logic [PAGE_BITS-1:0]                 page_sel;   // First page-select value
        logic [PAGE_BITS-1:0]                 act_page;   // Active page
        logic [FPT_SECTORS-1:0]               sect_prot;  // Sector protect bits
        logic [7:0]                           trim_addr;  // Loaded trim address
        logic [FPT_TRIM_BYTES-1:0][7:0]       trim_ov;    // Working overrides
        logic [FPT_TRIM_BYTES-1:0]            trim_vld;   // Override present
        logic                                 pready;     // Access-phase answer
        logic                                 pslverr;    // Unmapped access
        logic [31:0]                          prdata;     // Read data
        logic                                 prog_stb;   // Byte program pulse
        logic                                 erase_stb;  // Page erase pulse
        logic                                 mass_erase; // Mass erase pulse
        logic [PAGE_BITS+OFFS_BITS-1:0]       faddr;      // Flash address
        logic [7:0]                           fwdata;     // Flash write byte
        logic [FPT_TRIM_BYTES*8-1:0]          trim_out;   // Trim outputs
    } fpt_regs_type;

    fpt_regs_type r_q;  // Registered state
    fpt_regs_type r_d;  // Next state

    // Sector that holds a page: top three page bits, or the page itself
    function automatic logic [2:0] sector_of(input logic [PAGE_BITS-1:0] page);
        logic [7:0] wide;
        wide = 8'(page);
        if (NUM_PAGES >= FPT_SECTORS) begin
            sector_of = 3'(wide >> SECT_SHIFT);
        end else begin
            sector_of = wide[2:0];
        end
    endfunction

    // Whether user code may alter a page
    function automatic logic page_writable(input logic [PAGE_BITS-1:0] page,
                                           input logic [FPT_SECTORS-1:0] prot,
                                           input logic flash_write_protect_option);
        page_writable = flash_write_protect_option && !prot[sector_of(page)];
    endfunction

    // Working value of one trim byte
    function automatic logic [7:0] trim_byte(input fpt_regs_type r,
                                             input logic [FPT_TRIM_BYTES*8-1:0] fac,
                                             input int unsigned idx);
        if (r.trim_vld[idx]) begin
            trim_byte = r.trim_ov[idx];
        end else begin
            trim_byte = fac[idx*8 +: 8];
        end
    endfunction

    // Address decode and transfer phases
    logic [11:0] idx;        // Register index
    logic        aligned;    // Word-aligned access
    logic        setup;      // Setup cycle seen
    logic        commit;     // Edge at which the transfer completes
    logic        mapped;     // Index hits a register
    logic        trim_ok;    // Trim address in range
    logic [4:0]  trim_idx;   // Trim byte index

    assign idx      = paddr_i[FPT_ADDR_W-1:2];
    assign aligned  = (paddr_i[1:0] == FPT_BYTE_SEL_ZERO);
    assign setup    = psel_i && !penable_i;
    assign commit   = psel_i && penable_i && r_q.pready;
    assign trim_ok  = (r_q.trim_addr <= FPT_TRIM_LAST);
    assign trim_idx = r_q.trim_addr[4:0];
    assign mapped   = aligned && (idx == FPT_IDX_TRIM_ADDR || idx == FPT_IDX_TRIM_DATA ||
                                  idx == FPT_IDX_CTRL      || idx == FPT_IDX_PAGE_SEL  ||
                                  idx == FPT_IDX_PROG      || idx == FPT_IDX_STATUS);

    // Next-state logic
    always_comb begin
        logic [7:0]           wbyte;
        logic [PAGE_BITS-1:0] wpage;
        logic [31:0]          rd;
        wbyte = pwdata_i[7:0];
        wpage = pwdata_i[PAGE_BITS-1:0];
        rd    = FPT_DATA_ZERO;
        r_d   = r_q;

        // Program and erase strobes last one cycle; mass erase lasts as long as the debug request
        r_d.prog_stb   = 1'b0;
        r_d.erase_stb  = 1'b0;
        r_d.mass_erase = 1'b0;

        // Debug port is the only mass erase source; it ignores the option bit
        if (dbg_mass_erase_i) begin
            r_d.mass_erase = 1'b1;
        end

        // No wait state: answer in the first access cycle
        r_d.pready  = setup;
        r_d.pslverr = setup && !mapped;

        // Read data prepared during setup
        if (setup && !pwrite_i && mapped) begin
            case (idx)
                FPT_IDX_TRIM_ADDR: rd[7:0] = r_q.trim_addr;
                FPT_IDX_TRIM_DATA: begin
                    if (trim_ok) begin
                        rd[7:0] = trim_byte(r_q, factory_trim_i, 32'(trim_idx));
                    end else begin
                        rd[7:0] = FPT_BYTE_ZERO;
                    end
                end
                FPT_IDX_PAGE_SEL:  rd[PAGE_BITS-1:0] = r_q.page_sel;
                FPT_IDX_STATUS: begin
                    rd[FPT_ST_STATE_LSB +: 3]         = r_q.state;
                    rd[FPT_ST_FWP_BIT]                = flash_write_protect_option_i;
                    rd[FPT_ST_ACT_LSB +: PAGE_BITS]   = r_q.act_page;
                    rd[FPT_ST_SECT_LSB +: FPT_SECTORS] = r_q.sect_prot;
                end
                default:           rd = FPT_DATA_ZERO;
            endcase
            r_d.prdata = rd;
        end else if (setup) begin
            r_d.prdata = FPT_DATA_ZERO;
        end

        // Writes take effect at the completing edge only
        if (commit && pwrite_i && mapped) begin
            case (idx)
                // Trim address load
                FPT_IDX_TRIM_ADDR: r_d.trim_addr = wbyte;
                // Trim working byte replace
                FPT_IDX_TRIM_DATA: begin
                    if (trim_ok) begin
                        r_d.trim_ov[trim_idx]  = wbyte;
                        r_d.trim_vld[trim_idx] = 1'b1;
                    end
                end
                // Control register key and command decode
                FPT_IDX_CTRL: begin
                    case (r_q.state)
                        FPT_LOCKED: begin
                            if (wbyte == FPT_KEY_FIRST) begin
                                r_d.state = FPT_KEY1;
                            end
                        end
                        FPT_KEY1: begin
                            if (wbyte == FPT_KEY_PAGE) begin
                                r_d.state = FPT_PAGE_PEND;
                            end else if (wbyte == FPT_KEY_SECTOR) begin
                                r_d.state = FPT_SECT_PEND;
                            end else begin
                                r_d.state = FPT_LOCKED;
                            end
                        end
                        FPT_UNLOCKED: begin
                            if (wbyte == FPT_CMD_ERASE &&
                                page_writable(r_q.act_page, r_q.sect_prot,
                                              flash_write_protect_option_i)) begin
                                r_d.erase_stb = 1'b1;
                                r_d.faddr = {r_q.act_page, {OFFS_BITS{1'b0}}};
                            end
                            r_d.state = FPT_LOCKED;
                        end
                        // After programming any control write relocks
                        FPT_PROGRAMMING: r_d.state = FPT_LOCKED;
                        default:         r_d.state = FPT_LOCKED;
                    endcase
                end
                // Page select, or sector protect when redirected
                FPT_IDX_PAGE_SEL: begin
                    case (r_q.state)
                        FPT_PAGE_PEND: begin
                            if (wpage == r_q.page_sel) begin
                                r_d.act_page = wpage;
                                r_d.state    = FPT_UNLOCKED;
                            end else begin
                                r_d.state    = FPT_LOCKED;
                            end
                        end
                        FPT_SECT_PEND: begin
                            r_d.sect_prot = wbyte;
                            r_d.state     = FPT_LOCKED;
                        end
                        FPT_LOCKED: r_d.page_sel = wpage;
                        default: begin
                            r_d.page_sel = wpage;
                            r_d.state    = FPT_LOCKED;
                        end
                    endcase
                end
                // Byte program into the active page
                FPT_IDX_PROG: begin
                    if ((r_q.state == FPT_UNLOCKED || r_q.state == FPT_PROGRAMMING) &&
                        page_writable(r_q.act_page, r_q.sect_prot,
                                      flash_write_protect_option_i)) begin
                        r_d.prog_stb = 1'b1;
                        r_d.faddr    = {r_q.act_page,
                                        pwdata_i[FPT_PROG_OFFS_LSB +: OFFS_BITS]};
                        r_d.fwdata   = pwdata_i[FPT_PROG_DATA_LSB +: 8];
                        r_d.state    = FPT_PROGRAMMING;
                    end
                end
                // Status is read only
                default: r_d.state = r_q.state;
            endcase
        end

        // Working trim bytes to the analog blocks
        for (int i = 0; i < FPT_TRIM_BYTES; i++) begin
            r_d.trim_out[i*8 +: 8] = trim_byte(r_d, factory_trim_i, i);
        end
    end

    // State register; reset locks and drops all overrides
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            r_q.state      <= FPT_LOCKED;
            r_q.page_sel   <= '0;
            r_q.act_page   <= '0;
            r_q.sect_prot  <= FPT_SECT_RESET;
            r_q.trim_addr  <= FPT_BYTE_ZERO;
            r_q.trim_ov    <= '0;
            r_q.trim_vld   <= '0;
            r_q.pready     <= 1'b0;
            r_q.pslverr    <= 1'b0;
            r_q.prdata     <= FPT_DATA_ZERO;
            r_q.prog_stb   <= 1'b0;
            r_q.erase_stb  <= 1'b0;
            r_q.mass_erase <= 1'b0;
            r_q.faddr      <= '0;
            r_q.fwdata     <= FPT_BYTE_ZERO;
            r_q.trim_out   <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    // Outputs straight from flip-flops
    assign prdata_o      = r_q.prdata;
    assign pready_o      = r_q.pready;
    assign pslverr_o     = r_q.pslverr;
    assign prog_stb_o    = r_q.prog_stb;
    assign erase_stb_o   = r_q.erase_stb;
    // Mass erase covers program flash only; info page serial bytes stay
    assign mass_erase_o  = r_q.mass_erase;
    assign flash_addr_o  = r_q.faddr;
    assign flash_wdata_o = r_q.fwdata;
    assign trim_value_o  = r_q.trim_out;

endmodule : fpt_flash_protect

`default_nettype wire

// ==== rtl/fpt_pkg.sv ====
// Package for the flash protect, unlock and trim access block.
// Assumes a 32-bit APB register port with word-indexed registers.
package fpt_pkg;

    // Register indices; the byte address is four times the index
    localparam logic [11:0] FPT_IDX_TRIM_ADDR = 12'hff6; // Trim address
    localparam logic [11:0] FPT_IDX_TRIM_DATA = 12'hff7; // trim_data_port
    localparam logic [11:0] FPT_IDX_CTRL      = 12'hff8; // Flash control
    localparam logic [11:0] FPT_IDX_PAGE_SEL  = 12'hff9; // Page select / sector protect
    localparam logic [11:0] FPT_IDX_PROG      = 12'hffa; // Byte program port
    localparam logic [11:0] FPT_IDX_STATUS    = 12'hffb; // Controller status

    // APB address width and byte-select field
    localparam int          FPT_ADDR_W        = 14;
    localparam logic [1:0]  FPT_BYTE_SEL_ZERO = 2'h0;

    // Control register key codes
    localparam logic [7:0]  FPT_KEY_FIRST     = 8'h73; // First key byte
    localparam logic [7:0]  FPT_KEY_PAGE      = 8'h8c; // Page unlock key
    localparam logic [7:0]  FPT_KEY_SECTOR    = 8'h5e; // Sector protect key
    localparam logic [7:0]  FPT_CMD_ERASE     = 8'h95; // Page erase command

    // Trim space
    localparam int          FPT_TRIM_BYTES    = 32;
    localparam logic [7:0]  FPT_TRIM_LAST     = 8'h1f; // Highest trim address
    localparam logic [7:0]  FPT_TRIM_INFO_LO  = 8'h20; // Info page base of trim

    // Sector protect
    localparam int          FPT_SECTORS       = 8;
    localparam logic [7:0]  FPT_SECT_RESET    = 8'h00;

    // Program port field layout
    localparam int          FPT_PROG_DATA_LSB = 0;  // Byte to program
    localparam int          FPT_PROG_OFFS_LSB = 8;  // Offset within page

    // Status register field layout
    localparam int          FPT_ST_STATE_LSB  = 0;  // Controller state, 3 bits
    localparam int          FPT_ST_FWP_BIT    = 4;  // Write-protect option
    localparam int          FPT_ST_ACT_LSB    = 8;  // Active page
    localparam int          FPT_ST_SECT_LSB   = 16; // Sector protect bits

    // Reset values
    localparam logic [31:0] FPT_DATA_ZERO     = 32'h0000_0000;
    localparam logic [7:0]  FPT_BYTE_ZERO     = 8'h00;

    // Controller states
    typedef enum logic [2:0] {
        FPT_LOCKED,      // No program or page erase possible
        FPT_KEY1,        // First key seen
        FPT_PAGE_PEND,   // Page key seen, waiting for page rewrite
        FPT_UNLOCKED,    // Active page open
        FPT_PROGRAMMING, // At least one byte programmed
        FPT_SECT_PEND    // Next page-select write goes to sector protect
    } fpt_state_type;

endpackage : fpt_pkg

// ==== test/fpt_flash_protect_checker.sv ====
// Checker for the flash protect block: bus timing, strobe causes, reset.
// Sees only the top ports; bound into every instance of the block.
`timescale 1ns/100ps
`default_nettype none
module fpt_flash_protect_checker
    import fpt_pkg::*;
#(
    parameter int PAGE_BITS = 2,
    parameter int OFFS_BITS = 9
) (
    input wire logic                           clk_i,
    input wire logic                           rst_n_i,
    input wire logic                           psel_i,
    input wire logic                           penable_i,
    input wire logic                           pwrite_i,
    input wire logic [FPT_ADDR_W-1:0]          paddr_i,
    input wire logic [31:0]                    pwdata_i,
    input wire logic [31:0]                    prdata_o,
    input wire logic                           pready_o,
    input wire logic                           pslverr_o,
    input wire logic                           flash_write_protect_option_i,
    input wire logic                           dbg_mass_erase_i,
    input wire logic [FPT_TRIM_BYTES*8-1:0]    factory_trim_i,
    input wire logic                           prog_stb_o,
    input wire logic                           erase_stb_o,
    input wire logic                           mass_erase_o,
    input wire logic [PAGE_BITS+OFFS_BITS-1:0] flash_addr_o,
    input wire logic [7:0]                     flash_wdata_o,
    input wire logic [FPT_TRIM_BYTES*8-1:0]    trim_value_o
);
    localparam logic [FPT_ADDR_W-1:0] A_CTRL = {FPT_IDX_CTRL, FPT_BYTE_SEL_ZERO};
    localparam logic [FPT_ADDR_W-1:0] A_PROG = {FPT_IDX_PROG, FPT_BYTE_SEL_ZERO};
    // Completing writes to control and program port
    wire logic wr_done = psel_i && penable_i && pready_o && pwrite_i;
    wire logic ctrl_wr = wr_done && (paddr_i == A_CTRL);
    wire logic prog_wr = wr_done && (paddr_i == A_PROG);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // Bus setup cycle and access cycle
    sequence setup_s;
        psel_i && !penable_i;
    endsequence
    sequence ack_s;
        pready_o ##1 !pready_o;
    endsequence
    ack_next_a: assert property (setup_s |=> ack_s)
        else $error("ready not a single pulse after setup");
    err_ack_a: assert property (pslverr_o |-> pready_o)
        else $error("error without ready");
    erase_cause_a: assert property (erase_stb_o |-> $past(ctrl_wr && flash_write_protect_option_i && pwdata_i[7:0] == FPT_CMD_ERASE))
        else $error("erase strobe without erase command");
    erase_page_a: assert property (erase_stb_o |-> flash_addr_o[OFFS_BITS-1:0] == '0)
        else $error("erase address not page base");
    prog_cause_a: assert property (prog_stb_o |-> $past(prog_wr && flash_write_protect_option_i))
        else $error("program strobe without program write");
    prog_data_a: assert property (prog_stb_o |-> flash_wdata_o == $past(pwdata_i[7:0]) && flash_addr_o[OFFS_BITS-1:0] == $past(pwdata_i[FPT_PROG_OFFS_LSB +: OFFS_BITS]))
        else $error("program byte or offset wrong");
    mass_dbg_a: assert property (dbg_mass_erase_i |=> mass_erase_o)
        else $error("debug mass erase not passed on");
    mass_only_a: assert property (mass_erase_o |-> $past(dbg_mass_erase_i))
        else $error("mass erase without debug request");
    reset_lock_a: assert property ($rose(rst_n_i) |-> (!prog_stb_o && !erase_stb_o) [*8])
        else $error("strobe right after reset");
    trim_restore_a: assert property ($rose(rst_n_i) |=> trim_value_o == factory_trim_i)
        else $error("trim not restored after reset");
endmodule // fpt_flash_protect_checker

bind fpt_flash_protect fpt_flash_protect_checker #(.PAGE_BITS(PAGE_BITS), .OFFS_BITS(OFFS_BITS)) u_chk (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o),
    .flash_write_protect_option_i(flash_write_protect_option_i),
    .dbg_mass_erase_i(dbg_mass_erase_i), .factory_trim_i(factory_trim_i),
    .prog_stb_o(prog_stb_o), .erase_stb_o(erase_stb_o), .mass_erase_o(mass_erase_o),
    .flash_addr_o(flash_addr_o), .flash_wdata_o(flash_wdata_o), .trim_value_o(trim_value_o));
`default_nettype wire

// ==== test/tb_flash_protect_unlock_trim.sv ====
// Self-checking bench for the flash protect, unlock and trim block.
// Drives the APB port, option bit and debug request directly.
`timescale 1ns/100ps
`default_nettype none
module tb_flash_protect_unlock_trim
    import fpt_pkg::*;
;
    logic                  clk_i, rst_n_i, psel_i, penable_i, pwrite_i, wp_i, dbg_i;
    logic [FPT_ADDR_W-1:0] paddr_i;
    logic [31:0]           pwdata_i, prdata_o, rd;
    logic                  pready_o, pslverr_o, prog_o, erase_o, mass_o, err;
    logic [255:0]          fac, trim_o, trim_m;
    logic [10:0]           faddr_o, last_addr;
    logic [7:0]            wdata_o, last_data, a, d;
    logic [8:0]            o;
    logic [1:0]            p;
    int                    n_mismatch, checked, seed, n_prog, n_erase, n_mass;

    fpt_flash_protect #(.PAGE_BITS(2), .OFFS_BITS(9)) uut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .flash_write_protect_option_i(wp_i),
        .dbg_mass_erase_i(dbg_i), .factory_trim_i(fac), .prog_stb_o(prog_o),
        .erase_stb_o(erase_o), .mass_erase_o(mass_o), .flash_addr_o(faddr_o),
        .flash_wdata_o(wdata_o), .trim_value_o(trim_o));

    // 50 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    // Count flash strobes mid-cycle
    always @(negedge clk_i) begin
        if (prog_o === 1'b1) begin
            n_prog++;
            last_addr = faddr_o;
            last_data = wdata_o;
        end
        if (erase_o === 1'b1) begin
            n_erase++;
            last_addr = faddr_o;
        end
        if (mass_o === 1'b1) n_mass++;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic finish_test;
        $display("checked=%0d mismatches=%0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // One APB transfer; waits for ready, then releases
    task automatic apb(input logic w, input logic [11:0] idx, input logic [31:0] dat);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= w;
        paddr_i <= {idx, FPT_BYTE_SEL_ZERO};
        pwdata_i <= dat;
        @(posedge clk_i);
        penable_i <= 1'b1;
        @(posedge clk_i);
        // Only the watchdog ends a wait for the answer
        while (pready_o !== 1'b1) begin
            @(posedge clk_i);
        end
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wr(input logic [11:0] idx, input logic [7:0] dat);
        apb(1'b1, idx, {24'h0, dat});
    endtask
    task automatic state_is(input logic [2:0] exp);
        apb(1'b0, FPT_IDX_STATUS, 32'h0);
        chk({29'h0, rd[2:0]}, {29'h0, exp});
    endtask
    task automatic unlock(input logic [1:0] pg);
        wr(FPT_IDX_PAGE_SEL, {6'h0, pg});
        wr(FPT_IDX_CTRL, FPT_KEY_FIRST);
        wr(FPT_IDX_CTRL, FPT_KEY_PAGE);
        wr(FPT_IDX_PAGE_SEL, {6'h0, pg});
    endtask
    function automatic logic [31:0] prog_word(input logic [8:0] off, input logic [7:0] b);
        return {15'h0, off, b};
    endfunction
    // Watchdog
    initial begin
        repeat (20000) @(posedge clk_i);
        n_mismatch++;
        finish_test();
    end
    initial begin
        seed = 38716;
        {psel_i, penable_i, pwrite_i, dbg_i, rst_n_i} = 5'h0;
        wp_i = 1'b1;
        paddr_i = '0;
        pwdata_i = 32'h0;
        for (int i = 0; i < 8; i++) fac[32*i +: 32] = $random(seed);
        trim_m = fac;
        repeat (20) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        apb(1'b0, FPT_IDX_STATUS, 32'h0);
        chk({29'h0, rd[2:0]}, 32'h0);
        chk({24'h0, rd[23:16]}, 32'h0);
        apb(1'b0, 12'h100, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        $display("reset and unmapped done");
        p = 2'($random(seed));
        unlock(p);
        state_is(3'h3);
        for (int i = 0; i < 3; i++) begin
            o = 9'($random(seed));
            d = 8'($random(seed));
            apb(1'b1, FPT_IDX_PROG, prog_word(o, d));
            chk({21'h0, last_addr}, {21'h0, p, o});
            chk({24'h0, last_data}, {24'h0, d});
        end
        chk(n_prog, 3);
        wr(FPT_IDX_CTRL, FPT_CMD_ERASE);
        chk(n_erase, 0);
        state_is(3'h0);
        unlock(p);
        wr(FPT_IDX_CTRL, FPT_CMD_ERASE);
        chk(n_erase, 1);
        chk({21'h0, last_addr}, {21'h0, p, 9'h0});
        apb(1'b1, FPT_IDX_PROG, prog_word(9'h0, 8'ha5));
        chk(n_prog, 3);
        $display("program and erase done");
        wr(FPT_IDX_PAGE_SEL, {6'h0, p});
        wr(FPT_IDX_CTRL, FPT_KEY_FIRST);
        wr(FPT_IDX_CTRL, FPT_KEY_PAGE);
        wr(FPT_IDX_PAGE_SEL, {6'h0, p ^ 2'h1});
        state_is(3'h0);
        wr(FPT_IDX_CTRL, FPT_KEY_FIRST);
        wr(FPT_IDX_CTRL, 8'h11);
        state_is(3'h0);
        wp_i <= 1'b0;
        unlock(p);
        apb(1'b1, FPT_IDX_PROG, prog_word(9'h1, 8'h3c));
        wr(FPT_IDX_CTRL, FPT_CMD_ERASE);
        chk(n_prog + n_erase, 4);
        dbg_i <= 1'b1;
        @(posedge clk_i);
        dbg_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        chk(n_mass, 1);
        for (int i = 0; i < 8; i++) chk(trim_o[32*i +: 32], fac[32*i +: 32]);
        wp_i <= 1'b1;
        $display("lock and option done");
        wr(FPT_IDX_CTRL, FPT_KEY_FIRST);
        wr(FPT_IDX_CTRL, FPT_KEY_SECTOR);
        wr(FPT_IDX_PAGE_SEL, 8'h1 << p);
        apb(1'b0, FPT_IDX_STATUS, 32'h0);
        chk({24'h0, rd[23:16]}, 32'h1 << p);
        unlock(p);
        apb(1'b1, FPT_IDX_PROG, prog_word(9'h2, 8'h11));
        chk(n_prog, 3);
        wr(FPT_IDX_CTRL, FPT_CMD_ERASE);
        chk(n_erase, 1);
        unlock(p ^ 2'h1);
        wr(FPT_IDX_CTRL, FPT_CMD_ERASE);
        chk(n_erase, 2);
        $display("sector protect done");
        for (int i = 0; i < 10; i++) begin
            a = 8'($random(seed)) & FPT_TRIM_LAST;
            d = 8'($random(seed));
            wr(FPT_IDX_TRIM_ADDR, a);
            wr(FPT_IDX_TRIM_DATA, d);
            trim_m[8*a +: 8] = d;
            apb(1'b0, FPT_IDX_TRIM_DATA, 32'h0);
            chk(rd, {24'h0, d});
            chk({24'h0, trim_o[8*a +: 8]}, {24'h0, d});
        end
        wr(FPT_IDX_TRIM_ADDR, FPT_TRIM_INFO_LO | 8'($random(seed)));
        wr(FPT_IDX_TRIM_DATA, 8'h5a);
        apb(1'b0, FPT_IDX_TRIM_DATA, 32'h0);
        chk(rd, 32'h0);
        for (int i = 0; i < 8; i++) chk(trim_o[32*i +: 32], trim_m[32*i +: 32]);
        $display("trim done");
        rst_n_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        for (int i = 0; i < 8; i++) chk(trim_o[32*i +: 32], fac[32*i +: 32]);
        apb(1'b0, FPT_IDX_STATUS, 32'h0);
        chk({21'h0, rd[23:16], rd[2:0]}, 32'h0);
        $display("second reset done");
        finish_test();
    end
endmodule // tb_flash_protect_unlock_trim
`default_nettype wire
